/* src/msc_pkg.sv */
// Package for the miscellaneous supply, clock and shutdown register bank
package msc_pkg;
  // Register offsets
  localparam logic [7:0] SUPPLY_MODE_STATUS_OFS = 8'h03;
  localparam logic [7:0] MISC_CONTROL_OFS = 8'h04;
  localparam logic [7:0] POWER_DOWN_CONTROL_OFS = 8'h05;
  localparam logic [7:0] CLOCK_WATCH_CONTROL_OFS = 8'h07;
  // Reset values
  localparam logic [7:0] SUPPLY_MODE_STATUS_RST = 8'h00;
  localparam logic [7:0] MISC_CONTROL_RST = 8'h00;
  localparam logic [7:0] POWER_DOWN_CONTROL_RST = 8'h15;
  localparam logic [7:0] CLOCK_WATCH_CONTROL_RST = 8'h00;
  // Monitor synchronisers leave reset with the I/O supply taken as present
  localparam logic [5:0] MONITOR_SYNC_RST = 6'h08;
  // Field positions
  localparam int ANALOG_FLAG_BIT = 7;
  localparam int IO_FLAG_BIT = 6;
  localparam int IGNORE_CLK_ERR_BIT = 6;
  localparam int BROADCAST_BIT = 1;
  localparam int PRECHARGE_LSB = 6;
  localparam int POLICY_LSB = 4;
  localparam int HOLD_LSB = 2;
  localparam int MISSING_CLK_BIT = 4;
  // Writable masks (read-only bits keep their value)
  localparam logic [7:0] SUPPLY_MODE_STATUS_WMASK = 8'h01;
  localparam logic [7:0] CLOCK_WATCH_CONTROL_WMASK = 8'hF0;
  // Power-down policy codes
  localparam logic [1:0] POLICY_IMMEDIATE = 2'h0;
  localparam logic [1:0] POLICY_TIMED = 2'h1;
  localparam logic [1:0] POLICY_CLEAN = 2'h2;
  // Times in microseconds and the clock rate
  localparam int CLK_MHZ = 250;
  localparam int PRECHARGE_US [4] = '{2500, 12500, 25000, 50000};
  localparam int HOLD_US [4] = '{30000, 25000, 10000, 5000};
  localparam int MISSING_CLK_US = 2000;
  localparam int MISSING_CLK_CYC = MISSING_CLK_US * CLK_MHZ;
  localparam int CNT_W = 24;

  // Register access strobe from the control port
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } msc_req_s;

  // Effective configuration handed to the rest of the device
  typedef struct packed {
    logic analog_supply_select;
    logic io_supply_select;
    logic ignore_clk_err;
    logic broadcast_address_enable;
    logic missing_clock_reset_enable;
  } msc_cfg_s;
endpackage

/* src/msc_regs.sv */
// Miscellaneous supply, clock and shutdown registers with their timers
// What this block does
// - Analog supply above 2V: flag set, mode forced 0
// - I/O supply above 2V: flag set, mode forced 0
// - Clock error resets unless ignore bit set
// - Broadcast bit enables fixed I2C target address
// - Precharge time 2.5/12.5/25/50 ms by code
// - Policy 0 drops regulator at once; 3 reserved
// - Policy 1 holds regulator until keep-alive timeout or clean shutdown
// - Policy 2 holds regulator until clean shutdown
// - Keep-alive 30/25/10/5 ms by code
// - Missing selected clock 2ms gives hard reset
// - Analog mode 0 regulator, mode 1 direct 1.8V
// - I/O mode 0 any voltage, mode 1 low only
module msc_regs
  import msc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Register access from the control port
  input wire msc_pkg::msc_req_s req,
  output logic [7:0] rdata,
  // Supply and clock monitors (asynchronous)
  input wire logic analog_above_2v,
  input wire logic io_above_2v,
  input wire logic io_supply_present,
  input wire logic clean_shutdown_done,
  input wire logic clock_error,
  input wire logic selected_clock_alive,
  // Host supply mode settings from another register, same clock
  input wire logic analog_supply_setting,
  input wire logic io_supply_setting,
  // Requests from the device
  input wire logic precharge_start,
  // Outputs
  output msc_pkg::msc_cfg_s cfg,
  output logic precharge_active,
  output logic digital_regulator_on,
  output logic device_reset
);
  import msc_pkg::*;

  // Stored registers
  logic [7:0] status_sw_r;
  logic [7:0] misc_control_r;
  logic [7:0] power_down_control_r;
  logic [7:0] clock_watch_control_r;
  // Monitor levels after their synchronisers, and the timers
  wire [5:0] mon_sync;
  logic [CNT_W-1:0] pre_cnt_r;
  logic [CNT_W-1:0] hold_cnt_r;
  logic [CNT_W-1:0] clk_cnt_r;

  // Output flops and their next values
  logic [7:0] rdata_r;
  msc_cfg_s cfg_r;
  logic pre_act_r;
  logic digital_regulator_r;
  logic rst_r;
  logic [7:0] rdata_nxt;
  msc_cfg_s cfg_nxt;

  // Monitors cross in from the analog side
  wire [5:0] async_in = {analog_above_2v, io_above_2v, io_supply_present,
                         clean_shutdown_done, clock_error, selected_clock_alive};
  wire analog_hi = mon_sync[5];
  wire io_hi = mon_sync[4];
  wire io_present = mon_sync[3];
  wire shut_done = mon_sync[2];
  wire clk_err = mon_sync[1];
  wire clk_alive = mon_sync[0];

  wire wr_status = req.wr && req.addr == SUPPLY_MODE_STATUS_OFS;
  wire wr_misc = req.wr && req.addr == MISC_CONTROL_OFS;
  wire wr_pd = req.wr && req.addr == POWER_DOWN_CONTROL_OFS;
  wire wr_cw = req.wr && req.addr == CLOCK_WATCH_CONTROL_OFS;

  // Status reads live values; only bit 0 is stored
  wire [7:0] status_view = {analog_hi, io_hi, 5'h00, status_sw_r[0]};

  wire [1:0] pre_code = power_down_control_r[PRECHARGE_LSB +: 2];
  wire [1:0] policy = power_down_control_r[POLICY_LSB +: 2];
  wire [1:0] hold_code = power_down_control_r[HOLD_LSB +: 2];
  wire [CNT_W-1:0] pre_load = CNT_W'(PRECHARGE_US[pre_code] * CLK_MHZ);
  wire [CNT_W-1:0] hold_load = CNT_W'(HOLD_US[hold_code] * CLK_MHZ);

  // Timer end points
  wire pre_busy = pre_cnt_r > CNT_W'(1);
  wire hold_expired = hold_cnt_r == '0;
  wire drop_timed = hold_expired || shut_done;

  // Reset causes, kept apart so each can be traced
  wire clk_watch_on = clock_watch_control_r[MISSING_CLK_BIT];
  wire clk_stop_done = clk_cnt_r == CNT_W'(MISSING_CLK_CYC);
  wire clk_err_reset = clk_err && !misc_control_r[IGNORE_CLK_ERR_BIT];
  wire clk_stop_reset = clk_watch_on && clk_stop_done;

  // Unmapped offsets read as zero
  always_comb begin
    unique case (req.addr)
      SUPPLY_MODE_STATUS_OFS: rdata_nxt = status_view;
      MISC_CONTROL_OFS: rdata_nxt = misc_control_r;
      POWER_DOWN_CONTROL_OFS: rdata_nxt = power_down_control_r;
      CLOCK_WATCH_CONTROL_OFS: rdata_nxt = clock_watch_control_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_comb begin
    // Mode 0 means internal regulator / full I/O range, so forcing low is safe
    cfg_nxt.analog_supply_select = 1'b0;
    cfg_nxt.io_supply_select = 1'b0;
    if (!analog_hi) begin
      cfg_nxt.analog_supply_select = analog_supply_setting;
    end
    if (!io_hi) begin
      cfg_nxt.io_supply_select = io_supply_setting;
    end
    cfg_nxt.ignore_clk_err = misc_control_r[IGNORE_CLK_ERR_BIT];
    cfg_nxt.broadcast_address_enable = misc_control_r[BROADCAST_BIT];
    cfg_nxt.missing_clock_reset_enable = clock_watch_control_r[MISSING_CLK_BIT];
  end

  // Two flops per monitor; the I/O supply counts as present during reset,
  // so leaving reset never drops the regulator by itself
  for (genvar i = 0; i < 6; i++) begin : g_sync
    logic sync1_r;
    logic sync2_r;
    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        sync1_r <= MONITOR_SYNC_RST[i];
        sync2_r <= MONITOR_SYNC_RST[i];
      end else begin
        sync1_r <= async_in[i];
        sync2_r <= sync1_r;
      end
    end
    assign mon_sync[i] = sync2_r;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      status_sw_r <= SUPPLY_MODE_STATUS_RST;
      misc_control_r <= MISC_CONTROL_RST;
      power_down_control_r <= POWER_DOWN_CONTROL_RST;
      clock_watch_control_r <= CLOCK_WATCH_CONTROL_RST;
      rdata_r <= 8'h00;
      cfg_r <= '0;
    end else begin
      if (wr_status) status_sw_r <= req.wdata & SUPPLY_MODE_STATUS_WMASK;
      if (wr_misc) misc_control_r <= req.wdata;
      // Reserved policy code 3 is stored as written; the keep-alive acts as for 0
      if (wr_pd) power_down_control_r <= req.wdata;
      if (wr_cw) clock_watch_control_r <= req.wdata & CLOCK_WATCH_CONTROL_WMASK;
      rdata_r <= rdata_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  // Input capacitor quick-charge timer
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pre_cnt_r <= '0;
      pre_act_r <= 1'b0;
    end else if (precharge_start) begin
      // A new start reloads the full time
      pre_cnt_r <= pre_load;
      pre_act_r <= 1'b1;
    end else if (pre_busy) begin
      pre_cnt_r <= pre_cnt_r - CNT_W'(1);
    end else begin
      pre_cnt_r <= '0;
      pre_act_r <= 1'b0;
    end
  end

  // Regulator keep-alive after I/O supply loss
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hold_cnt_r <= '0;
      digital_regulator_r <= 1'b1;
    end else if (io_present) begin
      // Supply back: keep-alive time reloaded
      hold_cnt_r <= hold_load;
      digital_regulator_r <= 1'b1;
    end else begin
      unique case (policy)
        POLICY_IMMEDIATE: digital_regulator_r <= 1'b0;
        POLICY_TIMED: begin
          // Clean shutdown may end the hold early; the timeout is the backstop
          if (!hold_expired) hold_cnt_r <= hold_cnt_r - CNT_W'(1);
          if (drop_timed) digital_regulator_r <= 1'b0;
        end
        POLICY_CLEAN: if (shut_done) digital_regulator_r <= 1'b0;
        default: digital_regulator_r <= 1'b0; // Reserved code treated as immediate
      endcase
    end
  end

  // Missing clock watchdog and clock error reset
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      clk_cnt_r <= '0;
      rst_r <= 1'b0;
    end else begin
      // Counter saturates so the reset request stays up while the clock is gone
      if (clk_alive || !clk_watch_on) clk_cnt_r <= '0;
      else if (!clk_stop_done) clk_cnt_r <= clk_cnt_r + CNT_W'(1);
      rst_r <= clk_err_reset || clk_stop_reset;
    end
  end

  assign rdata = rdata_r;
  assign cfg = cfg_r;
  assign precharge_active = pre_act_r;
  assign digital_regulator_on = digital_regulator_r;
  assign device_reset = rst_r;
endmodule

/* bench/msc_host.sv */
// Host model driving the register strobe
module msc_host
  import msc_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Strobe
  output msc_pkg::msc_req_s req
);
  logic rd_req = 1'b0;
  initial req = '0;
  // Raw skips the reserved-field masking
  task automatic xfer(input logic [7:0] a, d, input bit wr, raw);
    logic [7:0] m;
    m = raw ? d : a == 8'h04 ? d & 8'h42 : a == 8'h05 ? {d[7:2], 2'h1}
      : a == 8'h07 ? d & 8'h10 : 8'h00;
    @(negedge core_clk);
    req <= '{wr, a, m};
    rd_req <= !wr;
    @(negedge core_clk);
    req.wr <= 1'b0;
    rd_req <= 1'b0;
  endtask
endmodule

/* bench/msc_properties.sv */
// Assertions for the misc register bank
module msc_chk
  import msc_pkg::*;
(
  // Clock and bus
  input wire logic core_clk,
  input wire logic nrst,
  input wire msc_pkg::msc_req_s req,
  input wire logic [7:0] rdata,
  // Monitors and outputs
  input wire logic analog_above_2v,
  input wire logic io_above_2v,
  input wire logic io_supply_present,
  input wire logic clock_error,
  input wire logic precharge_start,
  input wire msc_pkg::msc_cfg_s cfg,
  input wire logic precharge_active,
  input wire logic digital_regulator_on,
  input wire logic device_reset
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_wr(logic [7:0] a);
    req.wr && req.addr == a ##1 !req.wr;
  endsequence
  chk_analog_forced: assert property (analog_above_2v[*4] |=> !cfg.analog_supply_select)
    else $error("select");
  chk_io_forced: assert property (io_above_2v[*4] |=> !cfg.io_supply_select)
    else $error("io select");
  chk_bcast_write: assert property (s_wr(8'h04) |=> ##1
    cfg.broadcast_address_enable == $past(req.wdata[1], 3)) else $error("bcast");
  chk_watch_write: assert property (s_wr(8'h07) |=> ##1
    cfg.missing_clock_reset_enable == $past(req.wdata[4], 3)) else $error("watch");
  chk_err_reset: assert property ((!cfg.ignore_clk_err && clock_error)[*4]
    |-> ##[0:3] device_reset) else $error("no reset");
  chk_reset_cause: assert property ($rose(device_reset) |-> $past(clock_error, 3)
    || cfg.missing_clock_reset_enable) else $error("reset");
  chk_reg_drop: assert property ($fell(digital_regulator_on)
    |-> !$past(io_supply_present, 2)) else $error("drop");
  chk_precharge: assert property (precharge_start |-> ##[1:2] precharge_active)
    else $error("charge");
  chk_ro_bits: assert property (req.addr == 8'h07 |=> rdata[3:0] == 4'h0)
    else $error("ro");
endmodule
bind msc_regs msc_chk u_chk (.core_clk, .nrst, .req, .rdata, .analog_above_2v, .io_above_2v,
  .io_supply_present, .clock_error, .precharge_start, .cfg, .precharge_active,
  .digital_regulator_on, .device_reset);

/* bench/testbench.sv */
// Bench for the misc register bank
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import msc_pkg::*;
  logic core_clk = 0, nrst = 0, an = 0, io = 0, iop = 1, csd = 0, cerr = 0, pst = 0;
  logic am = 0, iom = 0, alive = 1;
  logic pa, ron, drst, seen = 0;
  logic [7:0] rdata, d, q[$];
  logic [15:0] rs = 16'h550C;
  int errors = 0, compares = 0, cyc = 0;
  msc_req_s req;
  msc_cfg_s cfg;
  msc_host host (.core_clk(core_clk), .req(req));
  msc_regs dut (.core_clk(core_clk), .nrst(nrst), .req(req), .rdata(rdata),
    .analog_above_2v(an), .io_above_2v(io), .io_supply_present(iop),
    .clean_shutdown_done(csd), .clock_error(cerr), .selected_clock_alive(alive),
    .analog_supply_setting(am), .io_supply_setting(iom),
    .precharge_start(pst), .cfg(cfg), .precharge_active(pa),
    .digital_regulator_on(ron), .device_reset(drst));
  initial forever #2 core_clk = ~core_clk;
  function automatic logic [7:0] rnd();
    rs ^= rs << 7;
    rs ^= rs >> 9;
    rs ^= rs << 8;
    return rs[7:0];
  endfunction
  task automatic cmp(input logic [7:0] e, g);
    compares++;
    if (g !== e) errors++;
    if (g !== e) $display("mismatch %0t %h %h", $time, e, g);
  endtask
  task automatic rd(input logic [7:0] a, e);
    q.push_back(e);
    host.xfer(a, 8'h00, 0, 0);
  endtask
  task automatic give_verdict(input int late);
    errors += late;
    if (errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) seen <= host.rd_req;
  always @(negedge core_clk) if (seen) cmp(q.pop_front(), rdata);
  always @(posedge core_clk) if (++cyc == 3000) give_verdict(1);
  initial begin
    repeat (12) @(negedge core_clk);
    nrst = 1;
    rd(8'h03, SUPPLY_MODE_STATUS_RST);
    rd(8'h04, MISC_CONTROL_RST);
    rd(8'h05, POWER_DOWN_CONTROL_RST);
    rd(8'h07, CLOCK_WATCH_CONTROL_RST);
    rd(8'h06, 8'h00);
    repeat (8) begin
      d = rnd();
      host.xfer(8'h04, d, 1, 0);
      host.xfer(8'h07, ~d, 1, 0);
      rd(8'h04, d & 8'h42);
      cmp(8'(cfg), {5'h0, d[6], d[1], ~d[4]});
    end
    host.xfer(8'h03, 8'hFF, 1, 1);
    rd(8'h03, 8'h01);
    host.xfer(8'h07, 8'hFF, 1, 1);
    rd(8'h07, 8'hF0);
    alive = 0;
    am = 1;
    iom = 1;
    repeat (100) @(negedge core_clk);
    cmp({7'h0, drst}, 8'h00);
    cmp(8'(cfg) & 8'h18, 8'h18);
    alive = 1;
    an = 1;
    io = 1;
    repeat (4) @(negedge core_clk);
    rd(8'h03, 8'hC1);
    cmp(8'(cfg) & 8'h18, 8'h00);
    an = 0;
    repeat (4) @(negedge core_clk);
    rd(8'h03, 8'h41);
    cmp(8'(cfg) & 8'h18, 8'h10);
    pst = 1;
    @(negedge core_clk);
    pst = 0;
    repeat (50) @(negedge core_clk);
    cmp({7'h0, pa}, 8'h01);
    host.xfer(8'h05, 8'h01, 1, 0);
    iop = 0;
    repeat (5) @(negedge core_clk);
    cmp({7'h0, ron}, 8'h00);
    nrst = 0;
    iop = 1;
    @(negedge core_clk);
    nrst = 1;
    iop = 0;
    repeat (40) @(negedge core_clk);
    cmp({7'h0, ron}, 8'h01);
    iop = 1;
    repeat (4) @(negedge core_clk);
    host.xfer(8'h05, 8'h2D, 1, 0);
    rd(8'h05, 8'h2D);
    iop = 0;
    repeat (40) @(negedge core_clk);
    cmp({7'h0, ron}, 8'h01);
    csd = 1;
    cerr = 1;
    repeat (8) @(negedge core_clk);
    cmp({6'h0, ron, drst}, 8'h01);
    host.xfer(8'h04, 8'h40, 1, 0);
    repeat (8) @(negedge core_clk);
    cmp({7'h0, drst}, 8'h00);
    give_verdict(0);
  end
endmodule
